// ### design/srd_top.sv
// Safety release, discrepancy latch and diagnostic status bytes.
// Assumes an AHB-Lite master on clk and field pins asynchronous to clk.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`include "srd_defines.svh"

module srd_top #(
	parameter int unsigned BLINK_HALF_CYC = `SRD_CLK_HZ / (2 * `SRD_BLINK_HZ),
	parameter int unsigned DISC_CYC = `SRD_DISC_MS * (`SRD_CLK_HZ / 1000),
	parameter longint unsigned WARN_CYC = 64'(`SRD_WARN_MIN) * 64'd60 * 64'(`SRD_CLK_HZ)
) (
	// Clock, reset, enable.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Field pins.
	input wire srd_pkg::srd_pins_s pins,
	// Field outputs.
	output logic safety_output_a,
	output logic safety_output_b,
	output logic yellow_led,
	output logic nv_disc_out,
	output logic irq
);
	import srd_pkg::*;

	srd_pins_s pin_s;
	srd_state_e state_r, state_nxt;
	logic [1:0] ctrl_r;
	logic [7:0] req_r;
	logic [3:0] irq_st_r, irq_mask_r, irq_ev;
	logic dph_wr_r, dph_rd_r, rd_ready_r;
	logic [7:0] dph_addr_r;
	logic [31:0] hrdata_r, rd_mux;
	logic rbtn_q_r, abtn_q_r, rbtn_fall, abtn_fall;
	logic wr_req, ack_req, err_rst;
	logic both_live, actuated, defect, warn_any, err_cause, err_any;
	logic err_latch_r, warn_to_r, disc_r, disc_set, warn_prev_r, err_prev_r;
	logic [39:0] warn_cnt_r;
	logic [31:0] disc_cnt_r, blink_cnt_r;
	logic [2:0] slow_cnt_r;
	logic [1:0] restore_cnt_r;
	logic restoring, enable_cond, start, out_r, fast_r, slow_r, led_r;
	srd_resp_s resp;
	logic [7:0] warn_byte, err_byte;

	// Field pins cross into clk through two flops each.
	srd_sync #(.W($bits(srd_pins_s))) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(pins),
		.q(pin_s)
	);

	// Button history for falling-edge detection.
	always_ff @(posedge clk) begin
		if (rst) begin
			rbtn_q_r <= 1'b0;
			abtn_q_r <= 1'b0;
		end else if (ce) begin
			rbtn_q_r <= pin_s.reset_button;
			abtn_q_r <= pin_s.ack_button;
		end
	end
	assign rbtn_fall = rbtn_q_r & ~pin_s.reset_button;
	assign abtn_fall = abtn_q_r & ~pin_s.ack_button;

	// Bus phase tracking; reads take one wait state so data come from a flop.
	always_ff @(posedge clk) begin
		if (rst) begin
			dph_wr_r <= 1'b0;
			dph_rd_r <= 1'b0;
			rd_ready_r <= 1'b0;
			dph_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else if (ce) begin
			if (hready) begin
				dph_wr_r <= hsel & htrans[1] & hwrite;
				dph_rd_r <= hsel & htrans[1] & ~hwrite;
				if (hsel & htrans[1])
					dph_addr_r <= haddr[7:0];
			end
			rd_ready_r <= dph_rd_r & ~rd_ready_r;
			if (dph_rd_r & ~rd_ready_r)
				hrdata_r <= rd_mux;
		end
	end
	assign hreadyout = ~(dph_rd_r & ~rd_ready_r);
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// Request byte effects: ack on bit 6 set, error reset on bit 7 falling.
	assign wr_req = ce & dph_wr_r & (dph_addr_r == `SRD_OFF_REQ);
	assign ack_req = (wr_req & hwdata[`SRD_REQ_ACK]) | abtn_fall;
	assign err_rst = wr_req & req_r[`SRD_REQ_ERR_RST] & ~hwdata[`SRD_REQ_ERR_RST];

	// Software-written registers; status bits set by events win over clears.
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= `SRD_CTRL_RST;
			req_r <= `SRD_REQ_RST;
			irq_mask_r <= `SRD_IRQ_RST;
			irq_st_r <= `SRD_IRQ_RST;
		end else if (ce) begin
			if (dph_wr_r && dph_addr_r == `SRD_OFF_CTRL)
				ctrl_r <= hwdata[1:0];
			if (wr_req)
				req_r <= hwdata[7:0];
			if (dph_wr_r && dph_addr_r == `SRD_OFF_IRQ_MASK)
				irq_mask_r <= hwdata[3:0];
			if (dph_wr_r && dph_addr_r == `SRD_OFF_IRQ_ST)
				irq_st_r <= (irq_st_r & ~hwdata[3:0]) | irq_ev;
			else
				irq_st_r <= irq_st_r | irq_ev;
		end
	end
	assign irq = |(irq_st_r & irq_mask_r);

	// Condition terms from the synchronised pins.
	assign both_live = pin_s.safety_input_a & pin_s.safety_input_b;
	assign actuated = pin_s.actuator_present & pin_s.actuator_valid;
	assign defect = pin_s.actuator_present & ~pin_s.actuator_valid;
	assign warn_any = pin_s.overtemp | pin_s.out_fault_a | pin_s.out_fault_b |
		pin_s.cross_wire | pin_s.gw_comm_fault;
	assign err_cause = pin_s.internal_fault | defect;
	assign err_any = err_latch_r | warn_to_r | disc_r | err_cause;
	assign restoring = restore_cnt_r != `SRD_RESTORE_DONE;

	// Device errors latch; they clear once gone and reset by request or guard opening.
	always_ff @(posedge clk) begin
		if (rst) begin
			err_latch_r <= 1'b0;
		end else if (ce) begin
			if (err_cause)
				err_latch_r <= 1'b1;
			else if (err_rst | ~pin_s.actuator_present)
				err_latch_r <= 1'b0;
		end
	end

	// Warning timer; a warning held for the full time forces the outputs off.
	always_ff @(posedge clk) begin
		if (rst) begin
			warn_cnt_r <= 40'h00_0000_0000;
			warn_to_r <= 1'b0;
		end else if (ce) begin
			if (!warn_any)
				warn_cnt_r <= 40'h00_0000_0000;
			else if (!warn_to_r)
				warn_cnt_r <= warn_cnt_r + 40'h00_0000_0001;
			if (warn_any && !warn_to_r && warn_cnt_r == 40'(WARN_CYC - 64'd1))
				warn_to_r <= 1'b1;
			else if (!warn_any && (err_rst || !pin_s.actuator_present))
				warn_to_r <= 1'b0;
		end
	end

	// Discrepancy timer between the chained inputs.
	assign disc_set = ctrl_r[`SRD_CTRL_CHAIN_MON] & (pin_s.safety_input_a ^ pin_s.safety_input_b) &
		~disc_r & (disc_cnt_r == DISC_CYC - 1);
	always_ff @(posedge clk) begin
		if (rst) begin
			disc_cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			if (ctrl_r[`SRD_CTRL_CHAIN_MON] && (pin_s.safety_input_a ^ pin_s.safety_input_b) &&
				!disc_r)
				disc_cnt_r <= disc_cnt_r + 32'h0000_0001;
			else
				disc_cnt_r <= 32'h0000_0000;
		end
	end

	// Discrepancy latch, restored from the non-volatile cell after reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			disc_r <= 1'b0;
			restore_cnt_r <= 2'h0;
		end else if (ce) begin
			if (restoring)
				restore_cnt_r <= restore_cnt_r + 2'h1;
			if (disc_set || (restore_cnt_r == 2'h2 && pin_s.nv_disc))
				disc_r <= 1'b1;
			else if (ack_req)
				disc_r <= 1'b0;
		end
	end
	assign nv_disc_out = disc_r;

	// Release sequence.
	assign enable_cond = ~restoring & actuated & both_live & ~err_any;
	assign start = ctrl_r[`SRD_CTRL_MON_START] ? (pin_s.feedback_closed & rbtn_fall) :
		pin_s.feedback_closed;
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SRD_IDLE: begin
				if (err_any)
					state_nxt = SRD_LOCK;
				else if (enable_cond)
					state_nxt = SRD_ARMED;
			end
			SRD_ARMED: begin
				if (!enable_cond)
					state_nxt = err_any ? SRD_LOCK : SRD_IDLE;
				else if (start)
					state_nxt = SRD_ON;
			end
			SRD_ON: begin
				if (!enable_cond)
					state_nxt = err_any ? SRD_LOCK : SRD_IDLE;
			end
			SRD_LOCK: begin
				if (!err_any)
					state_nxt = SRD_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= SRD_IDLE;
			out_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			out_r <= state_nxt == SRD_ON;
		end
	end
	assign safety_output_a = out_r;
	assign safety_output_b = out_r;

	// Blink dividers: fast toggles every half period, slow every five of those.
	always_ff @(posedge clk) begin
		if (rst) begin
			blink_cnt_r <= 32'h0000_0000;
			slow_cnt_r <= 3'h0;
			fast_r <= 1'b0;
			slow_r <= 1'b0;
		end else if (ce) begin
			if (blink_cnt_r == BLINK_HALF_CYC - 1) begin
				blink_cnt_r <= 32'h0000_0000;
				fast_r <= ~fast_r;
				slow_cnt_r <= (slow_cnt_r == `SRD_SLOW_LAST) ? 3'h0 : slow_cnt_r + 3'h1;
				if (slow_cnt_r == `SRD_SLOW_LAST)
					slow_r <= ~slow_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
			end
		end
	end

	// Yellow indicator: steady when on, slow in limit zone, fast while waiting.
	always_ff @(posedge clk) begin
		if (rst)
			led_r <= 1'b0;
		else if (ce)
			led_r <= out_r ? (pin_s.actuator_hyst ? slow_r : 1'b1) :
				(state_r == SRD_ARMED) & fast_r;
	end
	assign yellow_led = led_r;

	// Status bytes.
	assign resp = '{error: err_any,
		warning: warn_any,
		limit_area: pin_s.actuator_present & pin_s.actuator_hyst,
		inputs_live: both_live,
		start_wait: state_r == SRD_ARMED,
		rsv: 1'b0,
		actuated: actuated,
		outputs_on: out_r};
	assign warn_byte = {1'b0, pin_s.gw_comm_fault, pin_s.internal_fault, 1'b0,
		pin_s.overtemp, pin_s.cross_wire, pin_s.out_fault_b, pin_s.out_fault_a};
	assign err_byte = {1'b0, disc_r, pin_s.internal_fault, defect,
		{4{warn_to_r}} & warn_byte[3:0]};

	// Interrupt events: outputs off, error rise, warning rise, discrepancy.
	always_ff @(posedge clk) begin
		if (rst) begin
			warn_prev_r <= 1'b0;
			err_prev_r <= 1'b0;
		end else if (ce) begin
			warn_prev_r <= warn_any;
			err_prev_r <= err_any;
		end
	end
	assign irq_ev = ce ? {disc_set, warn_any & ~warn_prev_r, err_any & ~err_prev_r,
		out_r & (state_nxt != SRD_ON)} : 4'h0;

	// Read multiplexer; unmapped offsets read zero.
	always_comb begin
		unique case (dph_addr_r)
			`SRD_OFF_CTRL: rd_mux = {30'h0000_0000, ctrl_r};
			`SRD_OFF_REQ: rd_mux = {24'h00_0000, req_r};
			`SRD_OFF_RESP: rd_mux = {24'h00_0000, resp};
			`SRD_OFF_WARN: rd_mux = {24'h00_0000, warn_byte};
			`SRD_OFF_ERR: rd_mux = {24'h00_0000, err_byte};
			`SRD_OFF_IRQ_ST: rd_mux = {28'h000_0000, irq_st_r};
			`SRD_OFF_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_ERR_RESET: assert property (ce && err_rst && !err_cause |=> !err_latch_r)
		else $error("error latch survived a reset request");
	AST_RESP_LIVE: assert property (resp.inputs_live == (pin_s.safety_input_a && pin_s.safety_input_b))
		else $error("live bit disagrees with inputs");
	AST_RESP_LIMIT: assert property (resp.limit_area |-> pin_s.actuator_hyst)
		else $error("limit bit without hysteresis zone");
	AST_RESP_ERR: assert property (resp.error && ce |=> !out_r)
		else $error("outputs on while error reported");
	AST_ERR_BYTE: assert property (err_byte[4] == defect && err_byte[5] == pin_s.internal_fault)
		else $error("error byte fields wrong");
	AST_DISC_BIT: assert property (err_byte[6] == disc_r && warn_byte[6] == pin_s.gw_comm_fault)
		else $error("bit 6 fields wrong");
	AST_NO_EARLY: assert property (state_r != SRD_ON |-> !safety_output_a && !safety_output_b)
		else $error("outputs on outside release state");
	AST_AUTO: assert property (ce && !ctrl_r[0] && state_r == SRD_ARMED && enable_cond &&
		pin_s.feedback_closed |=> out_r ##1 (led_r || pin_s.actuator_hyst))
		else $error("automatic release missed");
	AST_MON: assert property (ce && ctrl_r[0] && state_r == SRD_ARMED && !rbtn_fall |=> !out_r)
		else $error("monitored release without edge");
	AST_DISC: assert property (ce && disc_set |=> disc_r && !out_r)
		else $error("discrepancy not latched");
	AST_LOCK: assert property (disc_r |-> state_nxt != SRD_ON)
		else $error("release with discrepancy pending");
	AST_NV: assert property (ce && restore_cnt_r == 2'h2 && pin_s.nv_disc |=> nv_disc_out)
		else $error("stored discrepancy not restored");
	AST_ACK: assert property (ce && ack_req && !disc_set && !restoring |=> !disc_r)
		else $error("acknowledge ignored");
	AST_RESP_OUT: assert property (resp.outputs_on == safety_output_a && resp.actuated == actuated)
		else $error("response bits 0 or 1 wrong");
	AST_WARN_TO: assert property (ce && warn_any && !warn_to_r &&
		warn_cnt_r == 40'(WARN_CYC - 64'd1) |=> warn_to_r ##1 !out_r)
		else $error("warning timeout missed");

	COV_ON: cover property (state_r == SRD_ARMED ##1 state_r == SRD_ON);
	COV_DISC: cover property (disc_set ##[1:20] !disc_r);
	COV_WARN_TO: cover property (warn_to_r && !err_cause);
	COV_IRQ: cover property (irq);

endmodule : srd_top

// ### design/srd_defines.svh
// Constants of the safety release and diagnostic status block.
// Assumes a 250 MHz clock and a 32-bit AHB-Lite register port.
`ifndef SRD_DEFINES_SVH
`define SRD_DEFINES_SVH

// Register byte offsets.
`define SRD_OFF_CTRL 8'h00
`define SRD_OFF_REQ 8'h04
`define SRD_OFF_RESP 8'h08
`define SRD_OFF_WARN 8'h0C
`define SRD_OFF_ERR 8'h10
`define SRD_OFF_IRQ_ST 8'h14
`define SRD_OFF_IRQ_MASK 8'h18

// Control register fields and reset value.
`define SRD_CTRL_MON_START 0
`define SRD_CTRL_CHAIN_MON 1
`define SRD_CTRL_RST 2'h0

// Request byte fields and reset value.
`define SRD_REQ_ACK 6
`define SRD_REQ_ERR_RST 7
`define SRD_REQ_RST 8'h00

// Interrupt status fields and reset values.
`define SRD_IRQ_OUT_OFF 0
`define SRD_IRQ_ERROR 1
`define SRD_IRQ_WARNING 2
`define SRD_IRQ_DISC 3
`define SRD_IRQ_RST 4'h0

// Timing figures as printed, and the clock rate.
`define SRD_CLK_HZ 250000000
`define SRD_BLINK_HZ 5
`define SRD_DISC_MS 500
`define SRD_WARN_MIN 30
`define SRD_SLOW_LAST 3'h4
`define SRD_RESTORE_DONE 2'h3

`endif

// ### design/srd_pkg.sv
// Types of the safety release and diagnostic status block.
// Assumes nothing beyond the constants header.
package srd_pkg;

	// Release sequence; Gray codes along idle, armed, on.
	typedef enum logic [1:0] {
		SRD_IDLE = 2'b00,
		SRD_ARMED = 2'b01,
		SRD_ON = 2'b11,
		SRD_LOCK = 2'b10
	} srd_state_e;

	// Field pins, all asynchronous to clk.
	typedef struct packed {
		logic nv_disc;
		logic gw_comm_fault;
		logic cross_wire;
		logic out_fault_b;
		logic out_fault_a;
		logic internal_fault;
		logic overtemp;
		logic actuator_hyst;
		logic actuator_valid;
		logic actuator_present;
		logic ack_button;
		logic reset_button;
		logic feedback_closed;
		logic safety_input_b;
		logic safety_input_a;
	} srd_pins_s;

	// Response byte, bit 7 first.
	typedef struct packed {
		logic error;
		logic warning;
		logic limit_area;
		logic inputs_live;
		logic start_wait;
		logic rsv;
		logic actuated;
		logic outputs_on;
	} srd_resp_s;

endpackage : srd_pkg

// ### design/srd_sync.sv
// Two-flop synchroniser bank for the field pins.
// Assumes its inputs are asynchronous; outputs are clk-domain levels.
module srd_sync #(
	parameter int W = 8
) (
	// Clock, reset, enable.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Data.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// One pair of flops per bit; the first flop feeds only the second.
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_r;
		always_ff @(posedge clk) begin
			if (rst) begin
				meta_r <= 1'b0;
				q[i] <= 1'b0;
			end else if (ce) begin
				meta_r <= d[i];
				q[i] <= meta_r;
			end
		end
	end

endmodule : srd_sync

// ### sim/srd_field_model.sv
// Field-side model: sensor pin levels plus the non-volatile discrepancy cell.
// Assumes the bench drives the pin levels and a supply flag in step with clk.
module srd_field_model (
	// Clock and supply.
	input wire logic clk,
	input wire logic supply_on,
	// Levels from the bench and latch level from the block.
	input wire logic [13:0] drive,
	input wire logic nv_disc_out,
	// Pin bundle to the block.
	output srd_pkg::srd_pins_s pins
);
	import srd_pkg::*;
	logic nv_cell_r = 1'b0;

	// The cell follows the latch only while powered, so a supply loss keeps the fault.
	always_ff @(posedge clk) begin
		if (supply_on) begin
			nv_cell_r <= nv_disc_out;
		end
	end

	// The stored cell rides on top of the bench levels.
	assign pins = {nv_cell_r, drive};
endmodule : srd_field_model

// ### sim/tb_safety_release_and_diag_status.sv
// Self-checking bench of the safety release block over its register port.
// Assumes the design files and the field model are compiled first.
`include "srd_defines.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
	$display("FAIL %s expected %h seen %h", n, e, a); end end

module tb_safety_release_and_diag_status;
	timeunit 1ns;
	timeprecision 1ps;
	import srd_pkg::*;
	typedef struct {string nm; logic [31:0] exp; int sel;} srd_note_t;
	srd_note_t notes[$];
	srd_note_t n;
	logic clk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, supply_on = 1;
	logic out_chk = 0, rd_dph = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, meas = 0, act;
	logic [13:0] drive = 0;
	logic hreadyout, hresp, sa, sb, yellow_led, nv_disc_out, irq;
	logic [31:0] hrdata;
	srd_pins_s pins;
	int mismatches = 0, samples_checked = 0;
	int wpin[5] = '{10, 11, 12, 8, 13};
	int wbit[5] = '{0, 1, 2, 3, 6};

	srd_top #(.BLINK_HALF_CYC(8), .DISC_CYC(20), .WARN_CYC(50)) dut (
		.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
		.safety_output_a(sa), .safety_output_b(sb), .yellow_led(yellow_led),
		.nv_disc_out(nv_disc_out), .irq(irq)
	);
	srd_field_model field (
		.clk(clk), .supply_on(supply_on), .drive(drive), .nv_disc_out(nv_disc_out), .pins(pins)
	);

	// The clock runs at 250 MHz.
	always #2 clk = ~clk;

	// Takes the oldest note whenever a read completes or an output sample is flagged.
	always @(posedge clk) begin
		if ((rd_dph && hreadyout) || out_chk) begin
			n = notes.pop_front();
			act = (n.sel == 0) ? hrdata : (n.sel == 1) ? {28'h0, irq, nv_disc_out, sb, sa} : meas;
			`CHK(n.nm, n.exp, act)
		end
	end

	// Prints the verdict and stops the run.
	task automatic end_sim();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	// Waits a number of clock edges.
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask : cyc

	// One single AHB-Lite transfer; entered just after a rising edge.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0000_00, a};
		hwrite <= wr;
		do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		rd_dph <= ~wr;
		do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 100);
		rd_dph <= 1'b0;
		if (k >= 100) begin
			mismatches++;
			$display("FAIL bus ready expected 1 seen timeout");
			end_sim();
		end
	endtask : ahb

	// Notes the expected word, then reads it.
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		notes.push_back('{nm, e, 0});
		ahb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Notes the expected outputs {irq, nv latch, b, a} and flags one sample.
	task automatic oc(input string nm, input logic [3:0] e);
		notes.push_back('{nm, {28'h0000_000, e}, 1});
		out_chk <= 1'b1;
		@(posedge clk);
		out_chk <= 1'b0;
	endtask : oc

	// Counts yellow toggles over 32 cycles; optionally appends the final level.
	task automatic look(input string nm, input logic lvl, input logic [31:0] e);
		logic last;
		int t;
		t = 0;
		last = yellow_led;
		repeat (32) begin
			@(posedge clk);
			if (yellow_led !== last) t++;
			last = yellow_led;
		end
		meas = lvl ? {t[30:0], last} : t;
		notes.push_back('{nm, e, 2});
		out_chk <= 1'b1;
		@(posedge clk);
		out_chk <= 1'b0;
	endtask : look

	// Sets one pin level and lets it cross the synchroniser.
	task automatic pin(input int i, input logic v);
		drive[i] <= v;
		cyc(8);
	endtask : pin

	// Drops input a, then input b after a gap, then restores both.
	task automatic drop(input int gap);
		drive[0] <= 1'b0;
		cyc(gap);
		drive[1] <= 1'b0;
		cyc(8);
		drive[1:0] <= 2'b11;
		cyc(8);
	endtask : drop

	// Main sequence.
	initial begin
		void'($urandom(94528));
		cyc(10);
		rst <= 1'b0;
		cyc(4);
		for (int i = 0; i < 8; i++) rd("reset word", 8'(i * 4), 32'h0000_0000);
		ahb(1'b1, 8'h40, $urandom());
		rd("unmapped", 8'h40, 32'h0000_0000);
		// Armed but loop open: outputs off, yellow blinks.
		drive <= 14'h0063;
		cyc(8);
		rd("resp armed", `SRD_OFF_RESP, 32'h0000_001A);
		oc("outs armed", 4'b0000);
		look("blink", 1'b0, 32'h0000_0004);
		pin(2, 1'b1);
		oc("outs auto", 4'b0011);
		look("steady", 1'b1, 32'h0000_0001);
		rd("resp on", `SRD_OFF_RESP, 32'h0000_0013);
		pin(7, 1'b1);
		rd("resp hyst", `SRD_OFF_RESP, 32'h0000_0033);
		pin(7, 1'b0);
		// Each warning source lands on its own bit and outputs stay on.
		for (int i = 0; i < 5; i++) begin
			pin(wpin[i], 1'b1);
			rd("warn byte", `SRD_OFF_WARN, 32'h1 << wbit[i]);
			rd("resp warn", `SRD_OFF_RESP, 32'h0000_0053);
			pin(wpin[i], 1'b0);
		end
		rd("irq status", `SRD_OFF_IRQ_ST, 32'h0000_0004);
		oc("irq masked", 4'b0011);
		ahb(1'b1, `SRD_OFF_IRQ_MASK, 32'h0000_000F);
		oc("irq unmasked", 4'b1011);
		ahb(1'b1, `SRD_OFF_IRQ_ST, 32'h0000_000F);
		oc("irq cleared", 4'b0011);
		// A warning held too long cuts the outputs until an error reset.
		pin(8, 1'b1);
		cyc(60);
		oc("outs timeout", 4'b1000);
		rd("err timeout", `SRD_OFF_ERR, 32'h0000_0008);
		rd("resp error", `SRD_OFF_RESP, 32'h0000_00D2);
		pin(8, 1'b0);
		ahb(1'b1, `SRD_OFF_REQ, 32'h0000_0080);
		ahb(1'b1, `SRD_OFF_REQ, 32'h0000_0000);
		ahb(1'b1, `SRD_OFF_IRQ_ST, 32'h0000_000F);
		cyc(8);
		rd("err reset", `SRD_OFF_ERR, 32'h0000_0000);
		oc("outs reset", 4'b0011);
		pin(9, 1'b1);
		rd("err internal", `SRD_OFF_ERR, 32'h0000_0020);
		pin(9, 1'b0);
		ahb(1'b1, `SRD_OFF_REQ, 32'h0000_0080);
		ahb(1'b1, `SRD_OFF_REQ, 32'h0000_0000);
		// Chain monitoring: a short gap passes, a long one latches.
		ahb(1'b1, `SRD_OFF_IRQ_MASK, 32'h0000_0008);
		ahb(1'b1, `SRD_OFF_CTRL, 32'h0000_0002);
		drop($urandom_range(10, 1));
		rd("err short gap", `SRD_OFF_ERR, 32'h0000_0000);
		oc("outs short gap", 4'b0011);
		drop(30);
		rd("err long gap", `SRD_OFF_ERR, 32'h0000_0040);
		oc("outs latched", 4'b1100);
		rd("resp latched", `SRD_OFF_RESP, 32'h0000_0092);
		// Supply loss keeps the fault; the button edge clears it.
		supply_on <= 1'b0;
		rst <= 1'b1;
		cyc(10);
		rst <= 1'b0;
		cyc(8);
		supply_on <= 1'b1;
		cyc(2);
		rd("err after power", `SRD_OFF_ERR, 32'h0000_0040);
		oc("outs after power", 4'b0100);
		pin(4, 1'b1);
		pin(4, 1'b0);
		rd("err button ack", `SRD_OFF_ERR, 32'h0000_0000);
		oc("outs button ack", 4'b0011);
		// A second fault is acknowledged through the request byte.
		ahb(1'b1, `SRD_OFF_CTRL, 32'h0000_0002);
		drop(30);
		oc("outs second fault", 4'b0100);
		ahb(1'b1, `SRD_OFF_REQ, 32'h0000_0040);
		cyc(8);
		rd("err request ack", `SRD_OFF_ERR, 32'h0000_0000);
		oc("outs request ack", 4'b0011);
		// Monitored start: loop closed alone is not enough, the button release is.
		ahb(1'b1, `SRD_OFF_CTRL, 32'h0000_0000);
		pin(2, 1'b0);
		ahb(1'b1, `SRD_OFF_CTRL, 32'h0000_0001);
		// Feedback is not a release condition, so the actuator leaves to drop the outputs.
		pin(5, 1'b0);
		pin(5, 1'b1);
		pin(2, 1'b1);
		oc("outs loop only", 4'b0000);
		pin(3, 1'b1);
		oc("outs button held", 4'b0000);
		pin(3, 1'b0);
		oc("outs button fall", 4'b0011);
		end_sim();
	end

	// Cuts a hang short.
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		$display("FAIL run length expected end seen timeout");
		end_sim();
	end
endmodule : tb_safety_release_and_diag_status
